// file: design/nio_pkg.sv
`default_nettype none
package nio_pkg;

  // Command nibble layout.
  localparam int unsigned PORT_SEL_LSB = 0;
  localparam int unsigned PORT_SEL_W   = 2;
  localparam int unsigned OP_LSB       = 2;
  localparam int unsigned OP_W         = 2;
  localparam int unsigned NIB_W        = 4;

  // Operation codes carried in the command nibble.
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_OR    = 2'h2;
  localparam logic [1:0] OP_AND   = 2'h3;

  // Timing figures in ns, and the clock period.
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned CS_SETUP_NS     = 50;
  localparam int unsigned INST_SETUP_NS   = 100;
  localparam int unsigned INST_HOLD_NS    = 60;
  localparam int unsigned DATA_SETUP_NS   = 200;
  localparam int unsigned DATA_HOLD_NS    = 20;
  localparam int unsigned STROBE_LOW_NS   = 700;
  localparam int unsigned READ_ACCESS_NS  = 650;
  localparam int unsigned CS_HOLD_NS      = 50;

  // Least times rounded up to whole cycles, never below one.
  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction : cyc_up

  localparam int unsigned CS_SETUP_CYC   = cyc_up(CS_SETUP_NS);
  localparam int unsigned INST_SETUP_CYC = cyc_up(INST_SETUP_NS);
  localparam int unsigned INST_HOLD_CYC  = cyc_up(INST_HOLD_NS);
  localparam int unsigned DATA_SETUP_CYC = cyc_up(DATA_SETUP_NS);
  localparam int unsigned DATA_HOLD_CYC  = cyc_up(DATA_HOLD_NS);
  localparam int unsigned STROBE_LOW_CYC = cyc_up(STROBE_LOW_NS);
  localparam int unsigned READ_WAIT_CYC  = cyc_up(READ_ACCESS_NS);
  localparam int unsigned CS_HOLD_CYC    = cyc_up(CS_HOLD_NS);
  localparam int unsigned CNT_W          = 5;

  // A request from the user side.
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] port;
    logic [3:0] data;
  } nio_req_t;

  // The nibble bus as data and its enable.
  typedef struct packed {
    logic [3:0] out;
    logic       oe;
  } nio_bus_drv_t;

endpackage : nio_pkg
`default_nettype wire

// file: design/nio_shadow_mem.sv
`timescale 1ns/10ps
`default_nettype none
// Remembers the last value written to each expansion port, read out
// through a register so the host can report what it believes is driven.
module nio_shadow_mem #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW    = 2,
  parameter int unsigned DW    = 4
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  // Write side
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  // Read side
  input  wire logic [AW-1:0] rd_addr_in,
  output var  logic [DW-1:0] rd_data_out
);

  logic [DW-1:0] mem [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          mem[g] <= '0;
        end else if (wr_en_in && wr_addr_in == AW'(g)) begin
          mem[g] <= wr_data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : nio_shadow_mem
`default_nettype wire

// file: design/nio_host.sv
// Operation
// - Strobe rising edge moves data through port.
// - Host samples bus, then raises strobe.
// - Write data driven as strobe rises.
// - Dummy read precedes output-to-input read.
`timescale 1ns/10ps
`default_nettype none
module nio_host #(
  parameter int unsigned NPORTS = 4
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  // User request
  input  wire nio_pkg::nio_req_t req_in,
  input  wire logic             req_valid_in,
  output logic                  req_ready_out,
  // User answer
  output logic [3:0]            rd_data_out,
  output logic                  rd_valid_out,
  output logic [3:0]            shadow_data_out,
  // Expander pins
  output logic                  chip_select_n_out,
  output logic                  transfer_strobe_out,
  input  wire logic [3:0]       host_nibble_bus_in,
  output logic [3:0]            host_nibble_bus_out,
  output logic                  host_nibble_bus_oe_out
);

  typedef enum logic [2:0] {
    NIO_IDLE, NIO_CSET, NIO_CMD, NIO_LOW, NIO_DATA, NIO_RISE, NIO_HOLD
  } nio_state_t;

  nio_state_t                   state;
  logic [nio_pkg::CNT_W-1:0]    cnt;
  nio_pkg::nio_req_t            cur;
  logic [NPORTS-1:0]            is_output;
  logic                         dummy_pend;
  logic                         shadow_wr;

  localparam logic [nio_pkg::CNT_W-1:0] C_CS =
    nio_pkg::CNT_W'(nio_pkg::CS_SETUP_CYC);
  localparam logic [nio_pkg::CNT_W-1:0] C_INST =
    nio_pkg::CNT_W'(nio_pkg::INST_SETUP_CYC);
  localparam logic [nio_pkg::CNT_W-1:0] C_IHOLD =
    nio_pkg::CNT_W'(nio_pkg::INST_HOLD_CYC);
  localparam logic [nio_pkg::CNT_W-1:0] C_LOW =
    nio_pkg::CNT_W'(nio_pkg::STROBE_LOW_CYC);
  localparam logic [nio_pkg::CNT_W-1:0] C_RD =
    nio_pkg::CNT_W'(nio_pkg::READ_WAIT_CYC);
  localparam logic [nio_pkg::CNT_W-1:0] C_DHOLD =
    nio_pkg::CNT_W'(nio_pkg::DATA_HOLD_CYC);
  localparam logic [nio_pkg::CNT_W-1:0] C_CSH =
    nio_pkg::CNT_W'(nio_pkg::CS_HOLD_CYC);

  // Read wait must cover both the access time and the least low width.
  localparam logic [nio_pkg::CNT_W-1:0] C_RDLOW =
    (C_RD > C_LOW) ? C_RD : C_LOW;

  wire logic is_read = (cur.op == nio_pkg::OP_READ);

  // Sequencer: one strobe cycle per request, a dummy read first when
  // a port leaves output mode, since its drivers release slowly.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state      <= NIO_IDLE;
      cnt        <= '0;
      cur        <= '0;
      dummy_pend <= 1'b0;
    end else begin
      unique case (state)
        NIO_IDLE: begin
          if (req_valid_in) begin
            cur   <= req_in;
            cnt   <= C_CS;
            state <= NIO_CSET;
            dummy_pend <= (req_in.op == nio_pkg::OP_READ) &&
                          is_output[req_in.port];
          end
        end
        NIO_CSET: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            cnt   <= C_INST;
            state <= NIO_CMD;
          end
        end
        NIO_CMD: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            cnt   <= C_IHOLD;
            state <= NIO_LOW;
          end
        end
        NIO_LOW: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            cnt   <= is_read ? (C_RDLOW - C_IHOLD) : (C_LOW - C_IHOLD);
            state <= NIO_DATA;
          end
        end
        NIO_DATA: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            cnt   <= C_DHOLD;
            state <= NIO_RISE;
          end
        end
        NIO_RISE: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            cnt   <= C_CSH;
            state <= NIO_HOLD;
          end
        end
        NIO_HOLD: begin
          cnt <= cnt - 1'b1;
          if (cnt == 1) begin
            if (dummy_pend) begin
              dummy_pend <= 1'b0;
              cnt        <= C_CS;
              state      <= NIO_CSET;
            end else begin
              state <= NIO_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Pins. Chip select stays low across the whole frame.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chip_select_n_out   <= 1'b1;
      transfer_strobe_out <= 1'b1;
    end else begin
      chip_select_n_out   <= (state == NIO_IDLE) && !req_valid_in;
      transfer_strobe_out <= !(state == NIO_LOW || state == NIO_DATA);
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      host_nibble_bus_out    <= '0;
      host_nibble_bus_oe_out <= 1'b0;
    end else begin
      unique case (state)
        NIO_CSET, NIO_CMD: begin
          host_nibble_bus_out    <= {cur.op, cur.port};
          host_nibble_bus_oe_out <= 1'b1;
        end
        // The command is held past the strobe fall on reads too, so the
        // expander never latches a bus that is still turning around.
        NIO_LOW: begin
          host_nibble_bus_out    <= {cur.op, cur.port};
          host_nibble_bus_oe_out <= 1'b1;
        end
        NIO_DATA, NIO_RISE: begin
          host_nibble_bus_out    <= cur.data;
          host_nibble_bus_oe_out <= !is_read;
        end
        default: begin
          host_nibble_bus_out    <= '0;
          host_nibble_bus_oe_out <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      if (state == NIO_DATA && cnt == 1 && is_read && !dummy_pend) begin
        rd_data_out  <= host_nibble_bus_in;
        rd_valid_out <= 1'b1;
      end
    end
  end

  // Track expander port modes the host has set.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      is_output <= '0;
    end else if (state == NIO_RISE && cnt == 1) begin
      is_output[cur.port] <= !is_read;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (state == NIO_IDLE) && !req_valid_in;
    end
  end

  logic [3:0] shadow_rd;
  logic [3:0] next_shadow;
  always_comb begin
    unique case (cur.op)
      nio_pkg::OP_AND: next_shadow = shadow_rd & cur.data;
      nio_pkg::OP_OR:  next_shadow = shadow_rd | cur.data;
      default:         next_shadow = cur.data;
    endcase
  end
  assign shadow_wr = (state == NIO_RISE) && (cnt == C_DHOLD) && !is_read;

  nio_shadow_mem #(
    .DEPTH (NPORTS),
    .AW    (2),
    .DW    (4)
  ) u_shadow (
    .clk_in      (core_clk_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (shadow_wr),
    .wr_addr_in  (cur.port),
    .wr_data_in  (next_shadow),
    .rd_addr_in  (cur.port),
    .rd_data_out (shadow_rd)
  );

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shadow_data_out <= '0;
    end else begin
      shadow_data_out <= shadow_rd;
    end
  end

  a_cmd_at_fall: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $fell(transfer_strobe_out) |-> (host_nibble_bus_oe_out &&
      host_nibble_bus_out == {cur.op, cur.port}))
    else $error("Command not driven at strobe fall.");

  a_read_float: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    (!transfer_strobe_out && $past(state) == NIO_DATA && is_read)
      |-> !host_nibble_bus_oe_out)
    else $error("Host drives bus during read.");

  a_cs_frame: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    !transfer_strobe_out |-> !chip_select_n_out)
    else $error("Strobe low while deselected.");

  a_data_at_rise: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    ($rose(transfer_strobe_out) && !is_read) |->
      (host_nibble_bus_oe_out && host_nibble_bus_out == cur.data))
    else $error("Write data missing at strobe rise.");

  a_sample_low: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    rd_valid_out |-> !transfer_strobe_out ##1 transfer_strobe_out)
    else $error("Read sampled after strobe rise.");

endmodule : nio_host
`default_nettype wire

// file: tb/nio_expander_model.sv
`timescale 1ns/10ps
`default_nettype none
module nio_expander_model (
  // Host side
  input  wire logic        chip_select_n_in,
  input  wire logic        transfer_strobe_in,
  input  wire logic [3:0]  host_nibble_bus_in,
  output logic      [3:0]  host_nibble_bus_out,
  output logic             host_nibble_bus_oe_out,
  // Expansion ports
  input  wire logic [15:0] port_ext_in,
  output logic      [15:0] port_pins_out,
  output logic      [3:0]  port_oe_out
);
  logic [3:0] cmd;
  logic [3:0] port_latch [4];
  logic       eff_strobe;
  logic [1:0] sel;

  assign eff_strobe = chip_select_n_in | transfer_strobe_in;
  assign sel = cmd[1:0];

  // Ports power up as floating inputs.
  initial begin
    cmd = 4'h0;
    port_oe_out = 4'h0;
    for (int i = 0; i < 4; i++) begin
      port_latch[i] = 4'h0;
    end
  end

  always @(negedge eff_strobe) begin
    cmd = host_nibble_bus_in;
  end

  // An output port still shows its latch until a read releases it, so a
  // lone first read of such a port returns stale data.
  // Bus driven only when reading.
  always_comb begin
    host_nibble_bus_oe_out = !eff_strobe && cmd[3:2] == nio_pkg::OP_READ;
    host_nibble_bus_out = port_oe_out[sel] ? port_latch[sel]
                                           : port_ext_in[4*sel +: 4];
  end

  always @(posedge eff_strobe) begin
    case (cmd[3:2])
      nio_pkg::OP_WRITE: port_latch[sel] = host_nibble_bus_in;
      nio_pkg::OP_OR:    port_latch[sel] = port_latch[sel] | host_nibble_bus_in;
      nio_pkg::OP_AND:   port_latch[sel] = port_latch[sel] & host_nibble_bus_in;
      default:           port_latch[sel] = port_latch[sel];
    endcase
    port_oe_out[sel] = cmd[3:2] != nio_pkg::OP_READ;
  end

  for (genvar g = 0; g < 4; g++) begin : g_pins
    assign port_pins_out[4*g +: 4] = port_latch[g];
  end
endmodule : nio_expander_model
`default_nettype wire

// file: tb/nio_host_bench.sv
`timescale 1ns/10ps
`default_nettype none
module nio_host_bench;
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] port;
    logic [3:0] data;
    logic [3:0] expect_nib;
  } nio_row_t;
  localparam logic [15:0] EXT_PINS = 16'hc358;
  localparam int NROWS = 9;
  // Reads of ports a and d follow writes, so stale data would show.
  localparam nio_row_t ROWS [NROWS] = '{
    '{2'h1, 2'h0, 4'ha, 4'ha}, '{2'h2, 2'h0, 4'h5, 4'hf},
    '{2'h3, 2'h0, 4'h6, 4'h6}, '{2'h1, 2'h3, 4'h9, 4'h9},
    '{2'h0, 2'h1, 4'h0, 4'h5}, '{2'h0, 2'h0, 4'h0, 4'h8},
    '{2'h1, 2'h2, 4'h0, 4'h0}, '{2'h2, 2'h2, 4'h3, 4'h3},
    '{2'h0, 2'h3, 4'h0, 4'hc}};

  logic              core_clk_in;
  logic              rstn_in;
  nio_pkg::nio_req_t req_in;
  logic              req_valid_in;
  logic              req_ready_out, rd_valid_out, cs_n, strobe;
  logic              host_oe, dev_oe;
  logic [3:0]        rd_data_out, host_out, dev_out, bus_wire, bus_last;
  logic [15:0]       pins_out, pins_wire;
  logic [3:0]        port_oe;
  logic [3:0]        got;
  logic [3:0]        shadow;
  int                errors;
  int                samples_checked;

  nio_host i_nio_host (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .req_in(req_in),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .shadow_data_out(shadow), .chip_select_n_out(cs_n),
    .transfer_strobe_out(strobe), .host_nibble_bus_in(bus_wire),
    .host_nibble_bus_out(host_out), .host_nibble_bus_oe_out(host_oe));

  nio_expander_model i_nio_expander_model (
    .chip_select_n_in(cs_n), .transfer_strobe_in(strobe),
    .host_nibble_bus_in(bus_wire), .host_nibble_bus_out(dev_out),
    .host_nibble_bus_oe_out(dev_oe), .port_ext_in(EXT_PINS),
    .port_pins_out(pins_out), .port_oe_out(port_oe));

  // A released bus shows the inverse of its last level, never a stale copy.
  assign bus_wire = host_oe ? host_out : (dev_oe ? dev_out : ~bus_last);
  always @(posedge core_clk_in) bus_last <= bus_wire;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins_wire[4*i +: 4] = port_oe[i] ? pins_out[4*i +: 4]
                                       : EXT_PINS[4*i +: 4];
    end
  end

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  task automatic check_nib(input string what, input logic [3:0] exp,
                           input logic [3:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_nib

  task automatic check_bit(input string what, input logic exp,
                           input logic seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_bit

  task automatic do_req(input nio_row_t r, output logic [3:0] res);
    int n;
    n = 0;
    // A read returns before its frame ends, so wait for the host to idle.
    while (req_ready_out !== 1'b1 && n < 400) begin
      @(negedge core_clk_in);
      n++;
    end
    req_in = '{op: r.op, port: r.port, data: r.data};
    req_valid_in = 1'b1;
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    while (n < 400 && !(r.op == 2'h0 ? rd_valid_out === 1'b1
                        : cs_n === 1'b1 && req_ready_out === 1'b1)) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 400) errors++;
    res = (r.op == 2'h0) ? rd_data_out : pins_wire[4*r.port +: 4];
  endtask : do_req

  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #(5000 * nio_pkg::CLK_PERIOD_NS);
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    bus_last = 4'h0;
    rstn_in = 1'b0;
    req_in = '0;
    req_valid_in = 1'b0;
    repeat (6) @(negedge core_clk_in);
    check_bit("cs_n in reset", 1'b1, cs_n);
    rstn_in = 1'b1;
    @(negedge core_clk_in);
    for (int i = 0; i < NROWS; i++) begin
      do_req(ROWS[i], got);
      check_nib("row result", ROWS[i].expect_nib, got);
      if (ROWS[i].op != 2'h0) check_nib("shadow copy", ROWS[i].expect_nib, shadow);
    end
    check_nib("port a released", 4'h8, pins_wire[3:0]);
    // Abort a read while the strobe is low; the pins must park at once.
    while (req_ready_out !== 1'b1) @(negedge core_clk_in);
    req_in = '{op: 2'h0, port: 2'h1, data: 4'h0};
    req_valid_in = 1'b1;
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    repeat (8) @(negedge core_clk_in);
    check_bit("strobe before abort", 1'b0, strobe);
    rstn_in = 1'b0;
    @(negedge core_clk_in);
    check_bit("strobe in reset", 1'b1, strobe);
    check_bit("cs_n after abort", 1'b1, cs_n);
    check_bit("host oe in reset", 1'b0, host_oe);
    check_bit("dev oe in reset", 1'b0, dev_oe);
    repeat (5) @(negedge core_clk_in);
    rstn_in = 1'b1;
    @(negedge core_clk_in);
    do_req(ROWS[8], got);
    check_nib("read after abort", 4'hc, got);
    check_nib("port b pins", 4'h5, pins_wire[7:4]);
    report_and_stop();
  end
endmodule : nio_host_bench
`default_nettype wire
